// ### hw/cal_level_key_gate.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cal_level_key_gate
(
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Write address channel
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [15:0]            s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  // Write data channel
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  // Write response channel
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  // Read address channel
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [15:0]            s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  // Read data channel
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  // Calibration controls
  output cal_key_pkg::cal_level_t     pll0_cal,
  output cal_key_pkg::cal_level_t     pll1_cal,
  output logic                        cal_access_enabled
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cal_key_pkg::wr_state_t wr_state_r;
  cal_key_pkg::rd_state_t rd_state_r;
  logic [15:0]            waddr_r;
  logic [7:0]             wbyte_r;
  logic                   wlane_r;
  logic [7:0]             key_r;
  logic                   unlocked_r;
  logic                   wr_fire;
  logic                   wr_key;
  logic                   wr_pll0;
  logic                   wr_pll1;
  logic                   wr_mapped;
  logic [31:0]            rdata_nxt;
  logic [1:0]             rresp_nxt;

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  // Ready stays low from its take until the response is accepted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      waddr_r       <= 16'h0000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      waddr_r       <= s_axi_awaddr;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b1;
      wbyte_r      <= 8'h00;
      wlane_r      <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      wbyte_r      <= s_axi_wdata[7:0];
      wlane_r      <= s_axi_wstrb[0];
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_fire   = ~s_axi_awready & ~s_axi_wready & (wr_state_r == cal_key_pkg::WR_IDLE);
  assign wr_key    = wr_fire & wlane_r & (waddr_r == cal_key_pkg::KEY_ADDR);
  assign wr_pll0   = wr_fire & wlane_r & unlocked_r
                     & (waddr_r == cal_key_pkg::PLL0_ADDR);
  assign wr_pll1   = wr_fire & wlane_r & unlocked_r
                     & (waddr_r == cal_key_pkg::PLL1_ADDR);
  assign wr_mapped = (waddr_r == cal_key_pkg::KEY_ADDR)
                     | (waddr_r == cal_key_pkg::PLL0_ADDR)
                     | (waddr_r == cal_key_pkg::PLL1_ADDR);

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_r  <= cal_key_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cal_key_pkg::RESP_OKAY;
    end
    else
    begin
      case (wr_state_r)
        cal_key_pkg::WR_IDLE:
        begin
          if (wr_fire)
          begin
            wr_state_r   <= cal_key_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? cal_key_pkg::RESP_OKAY : cal_key_pkg::RESP_SLVERR;
          end
        end
        cal_key_pkg::WR_RESP:
        begin
          if (s_axi_bready)
          begin
            wr_state_r   <= cal_key_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default:
        begin
          wr_state_r   <= cal_key_pkg::WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Access key
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key_r      <= cal_key_pkg::KEY_RESET;
      unlocked_r <= 1'b0;
    end
    else if (wr_key)
    begin
      key_r      <= wbyte_r;
      unlocked_r <= (wbyte_r == cal_key_pkg::KEY_UNLOCK);
    end
  end

  assign cal_access_enabled = unlocked_r;

  // ----------------------------------------------------------------
  // Calibration-level registers
  // ----------------------------------------------------------------
  cal_level_reg u_pll0_level
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_pll0),
    .wr_byte (wbyte_r),
    .level_q (pll0_cal)
  );

  cal_level_reg u_pll1_level
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_pll1),
    .wr_byte (wbyte_r),
    .level_q (pll1_cal)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = cal_key_pkg::RESP_OKAY;
    case (s_axi_araddr)
      cal_key_pkg::KEY_ADDR:  rdata_nxt[7:0] = key_r;
      cal_key_pkg::PLL0_ADDR: rdata_nxt[2:0] = {pll0_cal.level, pll0_cal.override_en};
      cal_key_pkg::PLL1_ADDR: rdata_nxt[2:0] = {pll1_cal.level, pll1_cal.override_en};
      default:                rresp_nxt      = cal_key_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_r   <= cal_key_pkg::RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_arready <= 1'b1;
      s_axi_rresp  <= cal_key_pkg::RESP_OKAY;
    end
    else
    begin
      case (rd_state_r)
        cal_key_pkg::RD_IDLE:
        begin
          if (s_axi_arvalid && s_axi_arready)
          begin
            rd_state_r   <= cal_key_pkg::RD_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_nxt;
            s_axi_arready <= 1'b0;
            s_axi_rresp  <= rresp_nxt;
          end
        end
        cal_key_pkg::RD_RESP:
        begin
          if (s_axi_rready)
          begin
            rd_state_r   <= cal_key_pkg::RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
          end
        end
        default:
        begin
          rd_state_r   <= cal_key_pkg::RD_IDLE;
          s_axi_arready <= 1'b1;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_locked_pll0_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && !unlocked_r && waddr_r == cal_key_pkg::PLL0_ADDR) |=> $stable(pll0_cal))
    else $error("locked write changed pll0 level");

  a_locked_pll1_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && !unlocked_r && waddr_r == cal_key_pkg::PLL1_ADDR) |=> $stable(pll1_cal))
    else $error("locked write changed pll1 level");

  a_unlocked_store: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wlane_r && unlocked_r && waddr_r == cal_key_pkg::PLL0_ADDR)
    |=> pll0_cal == $past(wbyte_r[2:0]))
    else $error("unlocked write not stored in pll0");

  a_key_unlock_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_access_enabled == (key_r == 8'hf9))
    else $error("access flag disagrees with key");

  a_reset_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (key_r == 8'h00 && pll0_cal.level == 2'h0 && pll1_cal.level == 2'h0))
    else $error("wrong values after reset");

  a_reset_override: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (!pll0_cal.override_en && !pll1_cal.override_en))
    else $error("override enabled after reset");

  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == cal_key_pkg::PLL0_ADDR)
    |=> (s_axi_rvalid && s_axi_rdata[31:3] == 29'h0))
    else $error("reserved read bits not zero");

  a_bresp_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before accept");

  c_unlock_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_pll0 ##[1:50] wr_key);
  c_locked_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !unlocked_r && waddr_r == cal_key_pkg::PLL1_ADDR);
  c_read_level: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready && s_axi_rdata[0]);

endmodule
`default_nettype wire

// ### hw/cal_key_pkg.sv
// Summary of operation
// - Calibration-level registers accept writes only while the key holds 0xf9.
// - Key resets to 0x00; any value except 0xf9 keeps protection on.
// - Bits [2:1] pick reference level 0..3, level 0 after reset.
// - Bit 0 enables manual reference control, cleared after reset.
`default_nettype none
package cal_key_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] KEY_IDX   = 16'h0fff;
  localparam logic [15:0] PLL0_IDX  = 16'h1488;
  localparam logic [15:0] PLL1_IDX  = 16'h1588;
  localparam logic [15:0] KEY_ADDR  = {KEY_IDX[13:0], 2'b00};
  localparam logic [15:0] PLL0_ADDR = {PLL0_IDX[13:0], 2'b00};
  localparam logic [15:0] PLL1_ADDR = {PLL1_IDX[13:0], 2'b00};

  // ----------------------------------------------------------------
  // Values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_UNLOCK  = 8'hf9;
  localparam logic [7:0] KEY_RESET   = 8'h00;
  localparam int         LEVEL_LSB   = 1;
  localparam int         LEVEL_MSB   = 2;
  localparam int         OVERRIDE_BIT = 0;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic       OVR_RESET   = 1'b0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] level;
    logic       override_en;
  } cal_level_t;

  typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
  typedef enum logic {RD_IDLE = 1'b0, RD_RESP = 1'b1} rd_state_t;

endpackage
`default_nettype wire

// ### hw/cal_level_reg.sv
`timescale 1ns/1ps
`default_nettype none
module cal_level_reg
(
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Gated write
  input  wire logic                   wr_en,
  input  wire logic [7:0]             wr_byte,
  // Stored fields
  output cal_key_pkg::cal_level_t     level_q
);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_q.level       <= cal_key_pkg::LEVEL_RESET;
      level_q.override_en <= cal_key_pkg::OVR_RESET;
    end
    else if (wr_en)
    begin
      level_q.level       <= wr_byte[cal_key_pkg::LEVEL_MSB:cal_key_pkg::LEVEL_LSB];
      level_q.override_en <= wr_byte[cal_key_pkg::OVERRIDE_BIT];
    end
  end

endmodule
`default_nettype wire

// ### testbench/tb_cal_level_key_gate.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cal_level_key_gate;
  // ------------------------------------------------------------
  // Clock, reset, bus signals
  // ------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, access_en;
  logic [15:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  cal_key_pkg::cal_level_t pll0_cal, pll1_cal;
  logic [7:0] key_m;
  logic [2:0] lvl_m [2];
  int fail_count = 0;
  int check_count = 0;

  always #2 aclk = ~aclk;

  cal_level_key_gate u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(awprot), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .pll0_cal(pll0_cal), .pll1_cal(pll1_cal),
    .cal_access_enabled(access_en));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] exp_rd(input logic [15:0] a);
    if (a == cal_key_pkg::KEY_ADDR) return {24'h0, key_m};
    if (a == cal_key_pkg::PLL0_ADDR) return {29'h0, lvl_m[0]};
    if (a == cal_key_pkg::PLL1_ADDR) return {29'h0, lvl_m[1]};
    return 32'h0;
  endfunction

  function automatic logic [1:0] exp_resp(input logic [15:0] a);
    if (a == cal_key_pkg::KEY_ADDR || a == cal_key_pkg::PLL0_ADDR ||
        a == cal_key_pkg::PLL1_ADDR) return cal_key_pkg::RESP_OKAY;
    return cal_key_pkg::RESP_SLVERR;
  endfunction

  // ------------------------------------------------------------
  // Bus tasks; handshakes judged at negedge, acted on at posedge
  // ------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    awaddr <= a;
    wdata <= {24'($urandom()), d};
    wstrb <= s;
    awprot <= 3'($urandom());
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !b_t; n++)
    begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      if (b_t) check({30'h0, bresp}, {30'h0, exp_resp(a)});
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
    @(posedge aclk);
    if (!b_t)
    begin
      fail_count++;
      wrap_up();
    end
    if (s[0] && a == cal_key_pkg::KEY_ADDR) key_m = d;
    if (s[0] && key_m == cal_key_pkg::KEY_UNLOCK)
    begin
      if (a == cal_key_pkg::PLL0_ADDR) lvl_m[0] = d[2:0];
      if (a == cal_key_pkg::PLL1_ADDR) lvl_m[1] = d[2:0];
    end
  endtask

  task automatic rd(input logic [15:0] a);
    logic r_t;
    r_t = 1'b0;
    araddr <= a;
    arprot <= 3'($urandom());
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !r_t; n++)
    begin
      @(negedge aclk);
      r_t = rvalid;
      if (r_t) check(rdata, exp_rd(a));
      if (r_t) check({30'h0, rresp}, {30'h0, exp_resp(a)});
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
    @(posedge aclk);
    if (!r_t)
    begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic ports();
    @(negedge aclk);
    check({31'h0, access_en}, {31'h0, key_m == cal_key_pkg::KEY_UNLOCK});
    check({29'h0, pll0_cal}, {29'h0, lvl_m[0]});
    check({29'h0, pll1_cal}, {29'h0, lvl_m[1]});
    @(posedge aclk);
  endtask

  task automatic all_regs();
    rd(cal_key_pkg::KEY_ADDR);
    rd(cal_key_pkg::PLL0_ADDR);
    rd(cal_key_pkg::PLL1_ADDR);
    ports();
  endtask

  task automatic reset_dut();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    key_m = cal_key_pkg::KEY_RESET;
    lvl_m[0] = {cal_key_pkg::LEVEL_RESET, cal_key_pkg::OVR_RESET};
    lvl_m[1] = {cal_key_pkg::LEVEL_RESET, cal_key_pkg::OVR_RESET};
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] k;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
    key_m = 8'h00;
    lvl_m[0] = 3'h0;
    lvl_m[1] = 3'h0;
    void'($urandom(35668));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    all_regs();
    // Locked with near-miss and random keys
    for (int i = 0; i < 8; i++)
    begin
      k = (i == 0) ? 8'hf8 : (i == 1) ? 8'hfa : 8'($urandom());
      if (k == cal_key_pkg::KEY_UNLOCK) k = 8'h00;
      wr(cal_key_pkg::KEY_ADDR, k, 4'hf);
      wr(cal_key_pkg::PLL0_ADDR, 8'($urandom()), 4'hf);
      wr(cal_key_pkg::PLL1_ADDR, 8'($urandom()), 4'hf);
      all_regs();
    end
    // Unlocked, one stored level write per PLL per power cycle: every code, override on and off
    for (int i = 0; i < 8; i++)
    begin
      reset_dut();
      wr(cal_key_pkg::KEY_ADDR, cal_key_pkg::KEY_UNLOCK, 4'($urandom()) | 4'h1);
      wr(cal_key_pkg::PLL0_ADDR, {5'($urandom()), 2'(i >> 1), 1'(i)}, 4'hf);
      wr(cal_key_pkg::PLL1_ADDR, {5'($urandom()), 2'(3 - (i >> 1)), 1'(~i)}, 4'hf);
      wr(cal_key_pkg::PLL0_ADDR, 8'($urandom()), 4'he);
      wr(cal_key_pkg::KEY_ADDR, cal_key_pkg::KEY_RESET, 4'h1);
      all_regs();
    end
    // Relock, then protected writes must be dropped
    wr(cal_key_pkg::KEY_ADDR, cal_key_pkg::KEY_RESET, 4'h1);
    wr(cal_key_pkg::PLL0_ADDR, 8'hff, 4'hf);
    wr(cal_key_pkg::PLL1_ADDR, 8'h00, 4'hf);
    all_regs();
    // Unmapped places, including the update strobe word
    wr(16'h003c, 8'h01, 4'hf);
    rd(16'h003c);
    wr(16'h1488, 8'h07, 4'hf);
    rd(16'h0ffc);
    all_regs();
    // Reset in mid-run restores defaults
    wr(cal_key_pkg::KEY_ADDR, cal_key_pkg::KEY_UNLOCK, 4'h1);
    reset_dut();
    all_regs();
    // Recommended sequence: unlock, level 1 with override, strobe, relock
    wr(cal_key_pkg::KEY_ADDR, cal_key_pkg::KEY_UNLOCK, 4'h1);
    wr(cal_key_pkg::PLL0_ADDR, 8'h03, 4'hf);
    wr(cal_key_pkg::PLL1_ADDR, 8'h03, 4'hf);
    wr(16'h003c, 8'h01, 4'h1);
    wr(cal_key_pkg::KEY_ADDR, cal_key_pkg::KEY_RESET, 4'h1);
    all_regs();
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
